// ===== hw/segment_pin_function_select.sv
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps

// How it works
// RULE1: the first select register holds one bit per pad for segments 16 to 31, bit 0 being segment 16.
// RULE2: the second select register holds one bit per pad for segments 32 to 47, bit 0 being segment 32.
// RULE3: the third select register holds one bit per pad for segments 48 to 63, bit 0 being segment 48.
// RULE4: the fourth select register has only bit 0, for segment 64, and bits 15 to 1 are reserved.
// RULE5: a select bit of 0 gives the pad to general-purpose I/O, 1 to the segment driver, and all clear at reset.
// RULE6: each select register is read and written as a 16-bit word or as its high and low bytes.
// RULE7: software should change select bits only while the display control field is 00 (display stopped).
// RULE8: a pad given to the segment function drives ground level while the display is stopped.
// RULE9: after reset the segment driver outputs are high impedance with input and output paths off.
// RULE10: writes to the reserved bits of the fourth register do nothing and those bits read as zero.
module segment_pin_function_select (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire segment_pin_function_select_pkg::display_ctrl_type display_control,
  input wire logic [segment_pin_function_select_pkg::NUM_PADS-1:0] seg_waveform,
  output logic [segment_pin_function_select_pkg::NUM_PADS-1:0] seg_mode,
  output logic [segment_pin_function_select_pkg::NUM_PADS-1:0] seg_out,
  output logic [segment_pin_function_select_pkg::NUM_PADS-1:0] seg_oe_n
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (segment_pin_function_select_pkg::NUM_PADS != 3 * 16 + 1)
  begin : g_bad_pads
    $error("pad count does not match the select register layout");
  end

  segment_pin_function_select_pkg::state_type st_reg;
  segment_pin_function_select_pkg::state_type st_next;
  logic accept;
  logic addr_hit;
  logic [1:0] addr_idx;
  logic [1:0] addr_lanes;
  logic [segment_pin_function_select_pkg::NUM_PADS-1:0] sel_vec;
  logic stopped;
  logic [15:0] wr_mask;

  // ----------------------------------------------------------------
  // address phase decode
  // ----------------------------------------------------------------
  assign accept = hsel && htrans[1] && hready;
  assign stopped = {display_control.display_control_high_bit, display_control.display_control_low_bit}
                   == segment_pin_function_select_pkg::DISPLAY_STOP;

  // match the word address against the four register indices
  always_comb
  begin
    addr_hit = 1'b0;
    addr_idx = 2'h0;
    // low two address bits pick the byte lane, so only the word part is matched here
    if (haddr[31:2] == {14'h0000, segment_pin_function_select_pkg::SEGMENT_SELECT_16_31_IDX})
    begin
      addr_hit = 1'b1;
      addr_idx = 2'h0;
    end
    else if (haddr[31:2] == {14'h0000, segment_pin_function_select_pkg::SEGMENT_SELECT_32_47_IDX})
    begin
      addr_hit = 1'b1;
      addr_idx = 2'h1;
    end
    else if (haddr[31:2] == {14'h0000, segment_pin_function_select_pkg::SEGMENT_SELECT_48_63_IDX})
    begin
      addr_hit = 1'b1;
      addr_idx = 2'h2;
    end
    else if (haddr[31:2] == {14'h0000, segment_pin_function_select_pkg::SEGMENT_SELECT_64_IDX})
    begin
      addr_hit = 1'b1;
      addr_idx = 2'h3;
    end
  end

  // RULE6: byte lanes
  // a byte at offset 0 or 1 hits one half; a word, or a halfword at offset 0, hits both; upper bytes are absent
  always_comb
  begin
    case (hsize)
      segment_pin_function_select_pkg::HSIZE_BYTE:
        addr_lanes = (haddr[1:0] == 2'h0) ? 2'b01 : ((haddr[1:0] == 2'h1) ? 2'b10 : 2'b00);
      segment_pin_function_select_pkg::HSIZE_HALF:
        addr_lanes = (haddr[1:0] == 2'h0) ? 2'b11 : 2'b00;
      segment_pin_function_select_pkg::HSIZE_WORD:
        addr_lanes = 2'b11;
      default:
        addr_lanes = 2'b00;
    endcase
  end

  // RULE1: segments 16 to 31 in the low register, bit 0 first
  // RULE2: segments 32 to 47 next
  // RULE3: segments 48 to 63 next
  // RULE4: only bit 0 of the last register reaches a pad
  assign sel_vec = {st_reg.sel[3][0], st_reg.sel[2], st_reg.sel[1], st_reg.sel[0]};
  assign wr_mask = {{8{st_reg.lanes[1]}}, {8{st_reg.lanes[0]}}};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // reads take one wait state so that a write just before is always seen
  always_comb
  begin
    st_next = st_reg;
    // write data phase: hwdata is valid now
    if (st_reg.phase == segment_pin_function_select_pkg::PH_WRITE && st_reg.hit)
    begin
      // RULE6: merge selected lanes only
      st_next.sel[st_reg.idx] = (st_reg.sel[st_reg.idx] & ~wr_mask) | (hwdata[15:0] & wr_mask);
    end
    // RULE10: reserved bits never hold a one
    st_next.sel[3] = st_next.sel[3] & segment_pin_function_select_pkg::SELECT_64_MASK;
    case (st_reg.phase)
      segment_pin_function_select_pkg::PH_READ_WAIT:
      begin
        st_next.hrdata = st_reg.hit ? {16'h0000, st_reg.sel[st_reg.idx]} : 32'h0000_0000;
        st_next.hreadyout = 1'b1;
        st_next.phase = segment_pin_function_select_pkg::PH_READ_DONE;
      end
      segment_pin_function_select_pkg::PH_IDLE,
      segment_pin_function_select_pkg::PH_WRITE,
      segment_pin_function_select_pkg::PH_READ_DONE:
      begin
        st_next.phase = segment_pin_function_select_pkg::PH_IDLE;
        if (accept)
        begin
          st_next.hit = addr_hit;
          st_next.idx = addr_idx;
          st_next.lanes = addr_lanes;
          st_next.phase = hwrite ? segment_pin_function_select_pkg::PH_WRITE
                                 : segment_pin_function_select_pkg::PH_READ_WAIT;
          st_next.hreadyout = hwrite;
        end
      end
      default:
      begin
        st_next.phase = segment_pin_function_select_pkg::PH_IDLE;
        st_next.hreadyout = 1'b1;
      end
    endcase
    // RULE5: a one hands the pad to the segment driver, a zero leaves it to the port
    st_next.seg_mode = sel_vec;
    st_next.seg_oe_n = ~sel_vec;
    // RULE8: ground level on selected pads while the display is stopped
    st_next.seg_out = stopped ? '0 : (seg_waveform & sel_vec);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // RULE5: all selects clear
  // RULE9: every segment driver released at reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg.sel <= {segment_pin_function_select_pkg::NUM_SELECT_REGS{segment_pin_function_select_pkg::SELECT_RESET}};
      st_reg.phase <= segment_pin_function_select_pkg::PH_IDLE;
      st_reg.hit <= 1'b0;
      st_reg.idx <= 2'h0;
      st_reg.lanes <= 2'b00;
      st_reg.hreadyout <= 1'b1;
      st_reg.hrdata <= 32'h0000_0000;
      st_reg.seg_mode <= '0;
      st_reg.seg_out <= '0;
      st_reg.seg_oe_n <= '1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops, except hresp tied to OKAY
  assign hrdata = st_reg.hrdata;
  assign hreadyout = st_reg.hreadyout;
  assign hresp = segment_pin_function_select_pkg::HRESP_OKAY;
  assign seg_mode = st_reg.seg_mode;
  assign seg_out = st_reg.seg_out;
  assign seg_oe_n = st_reg.seg_oe_n;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic first_cycle_reg;
  logic wr_full;

  // helper: marks the first edge after reset release
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      first_cycle_reg <= 1'b1;
    else
      first_cycle_reg <= 1'b0;
  end

  assign wr_full = st_reg.phase == segment_pin_function_select_pkg::PH_WRITE && st_reg.hit && st_reg.lanes == 2'b11;

  property p_sel_16_31;
    @(posedge hclk) disable iff (!hresetn)
    (wr_full && st_reg.idx == 2'h0) |=> ##1 seg_mode[15:0] == $past(hwdata[15:0], 2);
  endproperty
  a_sel_16_31: assert property (p_sel_16_31) else $error("segments 16-31 do not follow word write"); // RULE1

  property p_sel_32_47;
    @(posedge hclk) disable iff (!hresetn)
    (wr_full && st_reg.idx == 2'h1) |=> ##1 seg_mode[31:16] == $past(hwdata[15:0], 2);
  endproperty
  a_sel_32_47: assert property (p_sel_32_47) else $error("segments 32-47 do not follow word write"); // RULE2

  property p_sel_48_63;
    @(posedge hclk) disable iff (!hresetn)
    (wr_full && st_reg.idx == 2'h2) |=> ##1 seg_mode[47:32] == $past(hwdata[15:0], 2);
  endproperty
  a_sel_48_63: assert property (p_sel_48_63) else $error("segments 48-63 do not follow word write"); // RULE3

  property p_sel_64;
    @(posedge hclk) disable iff (!hresetn)
    (wr_full && st_reg.idx == 2'h3) |=> ##1 seg_mode[48] == $past(hwdata[0], 2);
  endproperty
  a_sel_64: assert property (p_sel_64) else $error("segment 64 does not follow write"); // RULE4

  property p_reset_state;
    @(posedge hclk) disable iff (!hresetn)
    first_cycle_reg |-> (seg_mode == '0 && seg_oe_n == '1 && st_reg.sel == '0);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("select or pad state wrong after reset"); // RULE5

  property p_byte_low_keeps_high;
    @(posedge hclk) disable iff (!hresetn)
    (st_reg.phase == segment_pin_function_select_pkg::PH_WRITE && st_reg.hit && st_reg.lanes == 2'b01)
      |=> st_reg.sel[$past(st_reg.idx)][15:8] == $past(st_reg.sel[st_reg.idx][15:8]);
  endproperty
  a_byte_low_keeps_high: assert property (p_byte_low_keeps_high) else $error("high byte changed"); // RULE6

  property p_stop_ground;
    @(posedge hclk) disable iff (!hresetn)
    stopped |=> (seg_out & ~seg_oe_n) == '0;
  endproperty
  a_stop_ground: assert property (p_stop_ground) else $error("segment pad not at ground while stopped"); // RULE8

  property p_release_follows;
    @(posedge hclk) disable iff (!hresetn)
    seg_oe_n == ~seg_mode;
  endproperty
  a_release_follows: assert property (p_release_follows) else $error("pad enable disagrees with select"); // RULE9

  property p_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
    (st_reg.phase == segment_pin_function_select_pkg::PH_READ_WAIT && st_reg.idx == 2'h3)
      |=> hreadyout && hrdata[31:1] == 31'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read non-zero"); // RULE10

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn)
    (accept && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read did not answer after one wait state");

endmodule : segment_pin_function_select

// ===== hw/segment_pin_function_select_pkg.sv
package segment_pin_function_select_pkg;

  // ----------------------------------------------------------------
  // register map (indices; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] SEGMENT_SELECT_16_31_IDX = 16'hF0F8;
  localparam logic [15:0] SEGMENT_SELECT_32_47_IDX = 16'hF0FA;
  localparam logic [15:0] SEGMENT_SELECT_48_63_IDX = 16'hF0FC;
  localparam logic [15:0] SEGMENT_SELECT_64_IDX = 16'hF0FE;
  localparam int NUM_SELECT_REGS = 4;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SELECT_RESET = 16'h0000;
  localparam logic [15:0] SELECT_64_MASK = 16'h0001;
  localparam int FIRST_SEGMENT = 16;
  localparam int NUM_PADS = 49;
  localparam logic [1:0] DISPLAY_STOP = 2'h0;

  // ----------------------------------------------------------------
  // ahb encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // display control bits coming from the display control register
  typedef struct packed {
    logic display_control_high_bit;
    logic display_control_low_bit;
  } display_ctrl_type;

  // bus data-phase tracking
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ_WAIT = 2'b10,
    PH_READ_DONE = 2'b11
  } bus_phase_type;

  // whole state of the block
  typedef struct packed {
    logic [NUM_SELECT_REGS-1:0][15:0] sel;
    bus_phase_type phase;
    logic hit;
    logic [1:0] idx;
    logic [1:0] lanes;
    logic hreadyout;
    logic [31:0] hrdata;
    logic [NUM_PADS-1:0] seg_mode;
    logic [NUM_PADS-1:0] seg_out;
    logic [NUM_PADS-1:0] seg_oe_n;
  } state_type;

endpackage : segment_pin_function_select_pkg

// ===== testbench/segment_panel_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// panel side: waveform source and pad levels
// ----------------------------------------------------------------
module segment_panel_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [segment_pin_function_select_pkg::NUM_PADS-1:0] seg_out,
  input wire logic [segment_pin_function_select_pkg::NUM_PADS-1:0] seg_oe_n,
  output logic [segment_pin_function_select_pkg::NUM_PADS-1:0] seg_waveform,
  output logic [segment_pin_function_select_pkg::NUM_PADS-1:0] pad_level
);
  logic [segment_pin_function_select_pkg::NUM_PADS-1:0] last_level;

  // waveform moves every cycle even while stopped, so a pad that leaks it is seen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      seg_waveform <= {1'b1, 48'hA5A5_C3C3_5A5A};
    end
    else
    begin
      seg_waveform <= {seg_waveform[47:0], ~seg_waveform[48]};
    end
  end

  // a released pad floats; show the inverse of its last level, not a stale copy
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      last_level <= '0;
    else
      last_level <= pad_level;
  end
  assign pad_level = (~seg_oe_n & seg_out) | (seg_oe_n & ~last_level);
endmodule : segment_panel_model

// ===== testbench/test_segment_pin_function_select.sv
`timescale 1ns/10ps

module test_segment_pin_function_select;
  localparam logic [31:0] BASE = {14'h0000, segment_pin_function_select_pkg::SEGMENT_SELECT_16_31_IDX, 2'h0};
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp;
  segment_pin_function_select_pkg::display_ctrl_type display_control;
  logic [48:0] seg_waveform, seg_mode, seg_out, seg_oe_n, pad_level, exp_mode, exp_out;
  logic [31:0] addrs [4];
  int n_errors = 0;
  int tests_run = 0;

  segment_pin_function_select segment_pin_function_select_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .display_control(display_control),
    .seg_waveform(seg_waveform), .seg_mode(seg_mode), .seg_out(seg_out), .seg_oe_n(seg_oe_n));

  segment_panel_model segment_panel_model_inst (.hclk(hclk), .hresetn(hresetn), .seg_out(seg_out),
    .seg_oe_n(seg_oe_n), .seg_waveform(seg_waveform), .pad_level(pad_level));

  always #25 hclk = ~hclk;

  // ----------------------------------------------------------------
  // verdict, comparison and bus tasks
  // ----------------------------------------------------------------
  task print_verdict;
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task check(input logic [48:0] seen, input logic [48:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // bounded wait so a stuck ready shows as a mismatch, not a hang
  task wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20)
    begin
      @(posedge hclk);
      n++;
    end
    check(49'(n < 20), 49'h1);
  endtask : wait_ready

  // one transfer of the current hsize: address phase held to ready, then data phase held to ready
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check(49'(hresp), 49'(segment_pin_function_select_pkg::HRESP_OKAY));
  endtask : xfer

  task rdc(input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    check(49'(rd), 49'(exp));
  endtask : rdc

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = segment_pin_function_select_pkg::HSIZE_WORD;
    hwdata = 32'h0000_0000;
    display_control = '0;
    for (int i = 0; i < 4; i++)
      addrs[i] = BASE + 32'(8 * i);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(seg_mode, '0);
    check(seg_oe_n, '1);
    check(seg_out, '0);
    for (int i = 0; i < 4; i++)
      rdc(addrs[i], 32'h0000_0000);
    // selects are changed only while the display is stopped
    xfer(addrs[0], 1'b1, 32'h0000_A5C3);
    xfer(addrs[1], 1'b1, 32'h0000_5A3C);
    xfer(addrs[2], 1'b1, 32'h0000_8001);
    xfer(addrs[3], 1'b1, 32'hFFFF_FFFF);
    rdc(addrs[0], 32'h0000_A5C3);
    rdc(addrs[1], 32'h0000_5A3C);
    rdc(addrs[2], 32'h0000_8001);
    rdc(addrs[3], 32'h0000_0001);
    exp_mode = {1'b1, 16'h8001, 16'h5A3C, 16'hA5C3};
    check(seg_mode, exp_mode);
    check(seg_oe_n, ~exp_mode);
    check(seg_out, '0);
    check(pad_level & exp_mode, '0);
    // gap between registers is unmapped: write dropped, read zero
    xfer(BASE + 32'h4, 1'b1, 32'hFFFF_FFFF);
    rdc(BASE + 32'h4, 32'h0000_0000);
    rdc(addrs[0], 32'h0000_A5C3);
    // every running display code passes the waveform to selected pads only
    for (int d = 1; d < 4; d++)
    begin
      display_control <= segment_pin_function_select_pkg::display_ctrl_type'(d[1:0]);
      repeat (3) @(posedge hclk);
      for (int k = 0; k < 6; k++)
      begin
        exp_out = seg_waveform & exp_mode;
        @(posedge hclk);
        check(seg_out, exp_out);
        check(pad_level & exp_mode, exp_out);
      end
    end
    display_control <= '0;
    repeat (3) @(posedge hclk);
    check(seg_out, '0);
    // byte and halfword writes touch only their own lanes
    hsize <= segment_pin_function_select_pkg::HSIZE_BYTE;
    xfer(addrs[0] + 32'h1, 1'b1, 32'h0000_3C00);
    xfer(addrs[1], 1'b1, 32'h0000_FF11);
    xfer(addrs[0] + 32'h2, 1'b1, 32'hFFFF_FFFF);
    xfer(addrs[3] + 32'h1, 1'b1, 32'h0000_FF00);
    hsize <= segment_pin_function_select_pkg::HSIZE_HALF;
    xfer(addrs[2], 1'b1, 32'h0000_1234);
    hsize <= segment_pin_function_select_pkg::HSIZE_WORD;
    rdc(addrs[0], 32'h0000_3CC3);
    rdc(addrs[1], 32'h0000_5A11);
    rdc(addrs[2], 32'h0000_1234);
    rdc(addrs[3], 32'h0000_0001);
    check(seg_mode, {1'b1, 16'h1234, 16'h5A11, 16'h3CC3});
    // reset in mid-run clears every select
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(seg_mode, '0);
    rdc(addrs[2], 32'h0000_0000);
    check(seg_oe_n, '1);
    print_verdict();
  end

  // watchdog sized well above the hundred or so cycles the sequence needs
  initial
  begin
    repeat (3000) @(posedge hclk);
    n_errors++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule : test_segment_pin_function_select
